// ===== hw/bcs_map.vh
// Register offsets, field positions, reset values and widths for break control.
`ifndef BCS_MAP_VH
`define BCS_MAP_VH
`define BCS_OFF_CONTROL   12'h000
`define BCS_OFF_COUNT     12'h004
`define BCS_OFF_DATA      12'h008
`define BCS_OFF_DMASK     12'h00C
`define BCS_OFF_IRQ_STAT  12'h010
`define BCS_OFF_IRQ_MASK  12'h014
`define BCS_CTRL_RESET    32'h00000000
`define BCS_CTRL_WMASK    32'h0030FCC9
`define BCS_BIT_ASMA      21
`define BCS_BIT_ASMB      20
`define BCS_BIT_FCA       15
`define BCS_BIT_FCB       14
`define BCS_BIT_FDA       13
`define BCS_BIT_FDB       12
`define BCS_BIT_TRACE     11
`define BCS_BIT_AFTA      10
`define BCS_BIT_BDATA     7
`define BCS_BIT_AFTB      6
`define BCS_BIT_CHAIN     3
`define BCS_BIT_CNTBRK    0
`define BCS_COUNT_W       12
`define BCS_COUNT_ONE     12'h001
`define BCS_IRQ_W         3
`endif

// ===== hw/bcs_chan_match.v
// Channel compare: address, ASID and optional masked data.
`timescale 1ns/1ps
`default_nettype none
module bcs_chan_match #(
  parameter AW = 32,
  parameter DW = 32
) (
  input  wire [AW-1:0] bus_addr,     // Observed address.
  input  wire [AW-1:0] cmp_addr,     // Break address.
  input  wire [7:0]    bus_asid,     // Observed ASID.
  input  wire [7:0]    cmp_asid,     // Break ASID.
  input  wire          asid_ignore,  // ASID not checked.
  input  wire [DW-1:0] bus_data,     // Observed data.
  input  wire [DW-1:0] cmp_data,     // Break data.
  input  wire [DW-1:0] data_mask,    // One excludes a data bit.
  input  wire          data_use,     // Data in the condition.
  input  wire          cycle_ok,     // Bus cycle qualifies.
  output wire          hit           // Condition met.
);
  wire asid_ok;
  wire data_ok;
  assign asid_ok = asid_ignore | (bus_asid == cmp_asid);
  assign data_ok = ~data_use | (((bus_data ^ cmp_data) & ~data_mask) == {DW{1'b0}});
  assign hit = cycle_ok & (bus_addr == cmp_addr) & asid_ok & data_ok;
endmodule // bcs_chan_match
`default_nettype wire

// ===== hw/bcs_top.v
// Break control settings block with APB register access.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"
// Operation
// R1: Control register is 32-bit read/write, cleared to zero at reset.
// R2: Reserved bits read zero; software writes zero there.
// R3: Bit 21 set skips the channel A ASID check.
// R4: Bit 20 set skips the channel B ASID check.
// R5: Bit 15 sticky, set by channel A CPU match, cleared by writing 0.
// R6: Bit 14 sticky, set by channel B CPU match, cleared by writing 0.
// R7: Bit 13 sticky, set by channel A DMA match, cleared by writing 0.
// R8: Bit 12 sticky, set by channel B DMA match, cleared by writing 0.
// R9: Bit 11 enables PC tracing; reset value disables it.
// R10: Bit 10 selects channel A break after execution when set.
// R11: Bit 7 includes channel B data in its condition.
// R12: Bit 6 selects channel B break after execution when set.
// R13: Bit 3 set needs channel A match then channel B match.
// R14: Bit 0 enables counted break on channel B only.
// R15: Each counted B match above one decrements count; break on match at one, count stays one.
// R16: Data mask bit one excludes that data bit from compare.
// R17: Writing one to a match flag leaves it unchanged.
module bcs_top #(
  parameter AW = 32,
  parameter DW = 32
) (
  input  wire          ref_clk,       // System clock.
  input  wire          rst_b,         // Synchronous reset, active low.
  input  wire          psel,          // APB select.
  input  wire          penable,       // APB enable.
  input  wire          pwrite,        // APB write.
  input  wire [11:0]   paddr,         // APB byte address.
  input  wire [31:0]   pwdata,        // APB write data.
  output reg  [31:0]   prdata,        // APB read data.
  output reg           pready,        // APB ready.
  output reg           pslverr,       // APB error.
  input  wire          cyc_valid,     // Bus cycle observed.
  input  wire          cyc_is_dma,    // Cycle is a DMA cycle.
  input  wire [AW-1:0] cyc_addr,      // Cycle address.
  input  wire [7:0]    cyc_asid,      // Cycle ASID.
  input  wire [DW-1:0] cyc_data,      // Cycle data.
  input  wire [AW-1:0] chan_a_addr,   // Channel A break address.
  input  wire [AW-1:0] chan_b_addr,   // Channel B break address.
  input  wire [7:0]    chan_a_asid_value, // Channel A break ASID.
  input  wire [7:0]    chan_b_asid_value, // Channel B break ASID.
  output reg           break_req,     // Break request pulse.
  output reg           break_after_exec, // Break after execution.
  output reg           pc_trace_enable,  // PC trace enable level.
  output reg           irq            // Interrupt level.
);
  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg  [31:0]             ctrl_q;
  reg  [31:0]             ctrl_d;
  reg  [`BCS_COUNT_W-1:0] count_q;
  reg  [`BCS_COUNT_W-1:0] count_d;
  reg  [DW-1:0]           chan_b_break_data;
  reg  [DW-1:0]           chan_b_data_mask;
  reg                     seq_armed_q;
  reg                     seq_armed_d;
  reg  [`BCS_IRQ_W-1:0]   istat_q;
  reg  [`BCS_IRQ_W-1:0]   istat_d;
  reg  [`BCS_IRQ_W-1:0]   imask_q;
  wire                    hit_a;
  wire                    hit_b;
  wire                    wr_en;
  wire                    rd_en;
  reg                     brk_d;
  reg                     brk_after_d;
  reg  [`BCS_IRQ_W-1:0]   ev;
  reg  [31:0]             rdata_d;
  reg                     err_d;

  function is_reg;
    input [11:0] a;
    begin
      is_reg = (a == `BCS_OFF_CONTROL) | (a == `BCS_OFF_COUNT) |
               (a == `BCS_OFF_DATA) | (a == `BCS_OFF_DMASK) |
               (a == `BCS_OFF_IRQ_STAT) | (a == `BCS_OFF_IRQ_MASK);
    end
  endfunction

  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;

  // ---------------------------------------------------------------
  // Channel comparators
  // ---------------------------------------------------------------
  // R3: Channel A ASID skip.
  bcs_chan_match #(.AW(AW), .DW(DW)) u_chan_a (
    .bus_addr    (cyc_addr),
    .cmp_addr    (chan_a_addr),
    .bus_asid    (cyc_asid),
    .cmp_asid    (chan_a_asid_value),
    .asid_ignore (ctrl_q[`BCS_BIT_ASMA]),
    .bus_data    (cyc_data),
    .cmp_data    ({DW{1'b0}}),
    .data_mask   ({DW{1'b1}}),
    .data_use    (1'b0),
    .cycle_ok    (cyc_valid),
    .hit         (hit_a)
  );

  // R4: Channel B ASID skip; R11 R16 data compare with mask.
  bcs_chan_match #(.AW(AW), .DW(DW)) u_chan_b (
    .bus_addr    (cyc_addr),
    .cmp_addr    (chan_b_addr),
    .bus_asid    (cyc_asid),
    .cmp_asid    (chan_b_asid_value),
    .asid_ignore (ctrl_q[`BCS_BIT_ASMB]),
    .bus_data    (cyc_data),
    .cmp_data    (chan_b_break_data),
    .data_mask   (chan_b_data_mask),
    .data_use    (ctrl_q[`BCS_BIT_BDATA]),
    .cycle_ok    (cyc_valid),
    .hit         (hit_b)
  );

  // ---------------------------------------------------------------
  // Break and flag logic
  // ---------------------------------------------------------------
  always @* begin
    ctrl_d      = ctrl_q;
    count_d     = count_q;
    seq_armed_d = seq_armed_q;
    brk_d       = 1'b0;
    brk_after_d = 1'b0;
    ev          = {`BCS_IRQ_W{1'b0}};
    // R2: Reserved bits never stored; R17 written ones keep flags.
    if (wr_en && paddr == `BCS_OFF_CONTROL) begin
      ctrl_d = (pwdata & `BCS_CTRL_WMASK & 32'hFFFF0FFF) |
               (ctrl_q & pwdata & 32'h0000F000);
    end
    if (wr_en && paddr == `BCS_OFF_COUNT) begin
      count_d = pwdata[`BCS_COUNT_W-1:0];
    end
    // R5 R6 R7 R8: Sticky flag set wins over clear.
    if (hit_a && !cyc_is_dma) ctrl_d[`BCS_BIT_FCA] = 1'b1;
    if (hit_b && !cyc_is_dma) ctrl_d[`BCS_BIT_FCB] = 1'b1;
    if (hit_a && cyc_is_dma)  ctrl_d[`BCS_BIT_FDA] = 1'b1;
    if (hit_b && cyc_is_dma)  ctrl_d[`BCS_BIT_FDB] = 1'b1;
    // R13: Sequential or independent combination.
    if (ctrl_q[`BCS_BIT_CHAIN]) begin
      if (hit_a) seq_armed_d = 1'b1;
      if (hit_b && seq_armed_q) begin
        brk_d       = 1'b1;
        brk_after_d = ctrl_q[`BCS_BIT_AFTB];
        seq_armed_d = 1'b0;
      end
    end else begin
      seq_armed_d = 1'b0;
      if (hit_a) begin
        brk_d = 1'b1;
        // R10: Channel A timing select.
        brk_after_d = ctrl_q[`BCS_BIT_AFTA];
      end
      if (hit_b) begin
        brk_d = 1'b1;
        // R12: Channel B timing select.
        brk_after_d = brk_after_d | ctrl_q[`BCS_BIT_AFTB];
      end
    end
    // R14 R15: Counted break on channel B.
    if (ctrl_q[`BCS_BIT_CNTBRK] && hit_b &&
        (!ctrl_q[`BCS_BIT_CHAIN] || seq_armed_q)) begin
      if (count_q != `BCS_COUNT_ONE) begin
        if (count_q != {`BCS_COUNT_W{1'b0}})
          count_d = count_q - `BCS_COUNT_ONE;
        if (!hit_a || ctrl_q[`BCS_BIT_CHAIN]) brk_d = 1'b0;
        if (!ctrl_q[`BCS_BIT_CHAIN] && hit_a)
          brk_after_d = ctrl_q[`BCS_BIT_AFTA];
      end
    end
    ev[0] = hit_a;
    ev[1] = hit_b;
    ev[2] = brk_d;
  end

  always @* begin
    istat_d = istat_q;
    if (wr_en && paddr == `BCS_OFF_IRQ_STAT)
      istat_d = istat_q & ~pwdata[`BCS_IRQ_W-1:0];
    istat_d = istat_d | ev;
  end

  always @* begin
    rdata_d = 32'h00000000;
    err_d   = ~is_reg(paddr);
    case (paddr)
      `BCS_OFF_CONTROL:  rdata_d = ctrl_q;
      `BCS_OFF_COUNT:    rdata_d = {20'h00000, count_q};
      `BCS_OFF_DATA:     rdata_d = chan_b_break_data;
      `BCS_OFF_DMASK:    rdata_d = chan_b_data_mask;
      `BCS_OFF_IRQ_STAT: rdata_d = {29'h00000000, istat_q};
      `BCS_OFF_IRQ_MASK: rdata_d = {29'h00000000, imask_q};
      default:           rdata_d = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------
  // Flip-flops
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      // R1: Reset clears the control register.
      ctrl_q            <= `BCS_CTRL_RESET;
      count_q           <= {`BCS_COUNT_W{1'b0}};
      chan_b_break_data <= {DW{1'b0}};
      chan_b_data_mask  <= {DW{1'b0}};
      seq_armed_q       <= 1'b0;
      istat_q           <= {`BCS_IRQ_W{1'b0}};
      imask_q           <= {`BCS_IRQ_W{1'b0}};
      prdata            <= 32'h00000000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      break_req         <= 1'b0;
      break_after_exec  <= 1'b0;
      pc_trace_enable   <= 1'b0;
      irq               <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      count_q     <= count_d;
      seq_armed_q <= seq_armed_d;
      istat_q     <= istat_d;
      if (wr_en && paddr == `BCS_OFF_DATA)
        chan_b_break_data <= pwdata[DW-1:0];
      if (wr_en && paddr == `BCS_OFF_DMASK)
        chan_b_data_mask <= pwdata[DW-1:0];
      if (wr_en && paddr == `BCS_OFF_IRQ_MASK)
        imask_q <= pwdata[`BCS_IRQ_W-1:0];
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & err_d;
      if (rd_en)
        prdata <= rdata_d;
      break_req        <= brk_d;
      break_after_exec <= brk_after_d;
      // R9: Trace enable follows its bit.
      pc_trace_enable  <= ctrl_d[`BCS_BIT_TRACE];
      irq              <= |(istat_d & imask_q);
    end
  end
endmodule // bcs_top
`default_nettype wire

// ===== testbench/bcs_checker.sv
// Concurrent checks on the break control block ports.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"
module bcs_checker (
  input wire logic        ref_clk,         // Clock.
  input wire logic        rst_b,           // Reset, active low.
  input wire logic        psel,            // Select.
  input wire logic        penable,         // Enable.
  input wire logic        pwrite,          // Write.
  input wire logic [11:0] paddr,           // Address.
  input wire logic [31:0] prdata,          // Read data.
  input wire logic        pready,          // Ready.
  input wire logic        pslverr,         // Error.
  input wire logic        cyc_valid,       // Cycle seen.
  input wire logic        break_req,       // Break pulse.
  input wire logic        pc_trace_enable, // Trace level.
  input wire logic        irq              // Interrupt.
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire wr_ctl = psel && penable && pwrite && paddr == `BCS_OFF_CONTROL;
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  sequence s_ans;
    pready ##1 !pready;
  endsequence
  AST_ANSWER: assert property (s_acc |=> s_ans)
    else $error("access not answered by one ready pulse");
  AST_CAUSE: assert property (pready |-> $past(psel && penable))
    else $error("ready without an access");
  AST_REFUSE: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0)
    else $error("refused read returned data");
  AST_RSVD: assert property (pready && !pwrite &&
    paddr == `BCS_OFF_CONTROL |-> (prdata & ~`BCS_CTRL_WMASK) == 32'h0)
    else $error("reserved control bits read as one");
  AST_TRACE: assert property ($changed(pc_trace_enable) |->
    $past(wr_ctl) || $past(wr_ctl, 2) || !$past(rst_b))
    else $error("trace enable moved without a control write");
  AST_BREAK: assert property (break_req |-> $past(cyc_valid))
    else $error("break without an observed cycle");
  AST_IRQ: assert property ($rose(irq) |-> $past(cyc_valid) ||
    $past(cyc_valid, 2) || $past(psel && pwrite) ||
    $past(psel && pwrite, 2))
    else $error("interrupt rose without a cause");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
endmodule // bcs_checker
`default_nettype wire

// ===== testbench/bcs_bus_model.sv
// Bus cycle source standing in for the CPU and DMA traffic.
`timescale 1ns/1ps
`default_nettype none
module bcs_bus_model (
  input  wire logic        ref_clk,   // Clock.
  input  wire logic        go,        // Present one cycle.
  input  wire logic [72:0] req,       // Kind, address, ASID, data.
  output var  logic        cyc_valid, // Cycle valid.
  output var  logic [72:0] cyc_info   // Cycle fields.
);
  initial cyc_valid = 1'b0;
  initial cyc_info = 73'h0;
  // Idle fields flip every cycle so stale values never match by luck.
  always @(posedge ref_clk) begin
    cyc_valid <= go;
    cyc_info <= go ? req : ~cyc_info;
  end
endmodule // bcs_bus_model
`default_nettype wire

// ===== testbench/break_control_settings_tb_top.sv
// Self-checking bench for the break control settings block.
`timescale 1ns/1ps
`default_nettype none
`include "bcs_map.vh"
module break_control_settings_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        go      = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [72:0] req     = 73'h0;
  logic [31:0] a_adr   = 32'h100;
  logic [31:0] b_adr   = 32'h200;
  logic [31:0] seed    = 32'h3782;
  logic [31:0] prdata, rd, v;
  logic [72:0] ci;
  logic        pready, pslverr, err, cv, brk, bae, la, trc, irq;
  int          fails = 0, num_checks = 0, nbrk = 0, cyc = 0, n;
  always #50 ref_clk = ~ref_clk;
  bcs_bus_model u_bcs_bus_model (.ref_clk(ref_clk), .go(go), .req(req),
    .cyc_valid(cv), .cyc_info(ci));
  bcs_top u_bcs_top (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cyc_valid(cv),
    .cyc_is_dma(ci[72]), .cyc_addr(ci[71:40]), .cyc_asid(ci[39:32]),
    .cyc_data(ci[31:0]), .chan_a_addr(a_adr), .chan_b_addr(b_adr),
    .chan_a_asid_value(8'h5A), .chan_b_asid_value(8'hA5),
    .break_req(brk), .break_after_exec(bae), .pc_trace_enable(trc),
    .irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] flag(input logic b, input logic m);
    return 32'h8000 >> (b + 2 * m);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hit(input logic b, input logic m, input logic [7:0] s,
                     input logic [31:0] d);
    @(posedge ref_clk);
    go <= 1'b1;
    req <= {m, b ? b_adr : a_adr, s, d};
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge ref_clk);
    chk(irq, exp);
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (brk === 1'b1) nbrk <= nbrk + 1;
    if (brk === 1'b1) la <= bae;
    if (cyc == 30000) begin
      fails = fails + 1;
      end_sim();
    end
  end
  initial begin
    @(posedge ref_clk);
    seed = lfsr(seed);
    a_adr <= seed;
    b_adr <= ~seed;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(1'b0, `BCS_OFF_CONTROL, 32'h0);
    chk(rd, `BCS_CTRL_RESET);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = ((i == 0) ? 32'hFFFFFFFF : seed) & `BCS_CTRL_WMASK;
      apb(1'b1, `BCS_OFF_CONTROL, v);
      apb(1'b0, `BCS_OFF_CONTROL, 32'h0);
      chk(rd, v & `BCS_CTRL_WMASK & 32'hFFFF0FFF);
      chk(trc, v[11]);
    end
    for (int k = 0; k < 4; k++) begin
      v = (k > 1) ? 32'h00300440 : 32'h00300000;
      apb(1'b1, `BCS_OFF_CONTROL, v);
      n = nbrk;
      hit(k[0], k[1], 8'h00, seed);
      chk(nbrk - n, 1);
      chk(la, k[1]);
      apb(1'b1, `BCS_OFF_CONTROL, v | 32'hF000);
      apb(1'b0, `BCS_OFF_CONTROL, 32'h0);
      chk(rd, v | flag(k[0], k[1]));
    end
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, `BCS_OFF_CONTROL, 32'h0);
      hit(1'b0, 1'b0, j ? 8'h5A : 8'hA5, seed);
      hit(1'b1, 1'b0, j ? 8'h5A : 8'hA5, seed);
      apb(1'b0, `BCS_OFF_CONTROL, 32'h0);
      chk(rd, j ? 32'h8000 : 32'h4000);
    end
    apb(1'b1, `BCS_OFF_DATA, 32'h12345678);
    apb(1'b1, `BCS_OFF_DMASK, 32'h000000FF);
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, `BCS_OFF_CONTROL, 32'h00100080);
      hit(1'b1, 1'b0, 8'h00, j ? 32'h12345778 : 32'h123456AA);
      apb(1'b0, `BCS_OFF_CONTROL, 32'h0);
      chk(rd, j ? 32'h00100080 : 32'h00104080);
    end
    apb(1'b1, `BCS_OFF_CONTROL, 32'h00300008);
    n = nbrk;
    hit(1'b1, 1'b0, 8'h00, seed);
    chk(nbrk - n, 0);
    hit(1'b0, 1'b0, 8'h00, seed);
    hit(1'b1, 1'b0, 8'h00, seed);
    chk(nbrk - n, 1);
    apb(1'b1, `BCS_OFF_COUNT, 32'h3);
    apb(1'b1, `BCS_OFF_CONTROL, 32'h00300001);
    n = nbrk;
    repeat (2) hit(1'b1, 1'b0, 8'h00, seed);
    chk(nbrk - n, 0);
    hit(1'b1, 1'b0, 8'h00, seed);
    chk(nbrk - n, 1);
    apb(1'b0, `BCS_OFF_COUNT, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `BCS_OFF_CONTROL, 32'h00300000);
    apb(1'b1, `BCS_OFF_IRQ_STAT, 32'h7);
    apb(1'b1, `BCS_OFF_IRQ_MASK, 32'h4);
    hit(1'b0, 1'b0, 8'h00, seed);
    chk_irq(1'b1);
    apb(1'b0, `BCS_OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, `BCS_OFF_IRQ_MASK, 32'h0);
    chk_irq(1'b0);
    apb(1'b1, `BCS_OFF_IRQ_MASK, 32'h4);
    apb(1'b1, `BCS_OFF_IRQ_STAT, 32'h7);
    chk_irq(1'b0);
    apb(1'b0, 12'h018, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    end_sim();
  end
endmodule // break_control_settings_tb_top
bind bcs_top bcs_checker u_bcs_checker (.ref_clk(ref_clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cyc_valid(cyc_valid), .break_req(break_req),
  .pc_trace_enable(pc_trace_enable), .irq(irq));
`default_nettype wire
